/* upis_pkg.sv */
package upis_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  UPIS_OFS_STATUS = 8'h00;  // Sticky flags, write one to clear
  localparam logic [7:0]  UPIS_OFS_MASK   = 8'h04;  // Interrupt mask, same layout
  localparam logic [7:0]  UPIS_OFS_CTRL   = 8'h08;  // Control: on-the-go bit
  localparam logic [31:0] UPIS_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] UPIS_MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] UPIS_IMPL_MASK  = 32'h03FF_FDFF;  // Bits 31:26 and 9 reserved
  localparam logic [31:0] UPIS_BUSRST_VAL = 32'h0000_0001;  // Only bus-reset flag left set

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int UPIS_BIT_BUS_RESET = 0;
  localparam int UPIS_BIT_SOF       = 1;
  localparam int UPIS_BIT_PSEUDO_FRAME_TICK_FLAG      = 2;
  localparam int UPIS_BIT_SUSPEND   = 3;
  localparam int UPIS_BIT_RESUME    = 4;
  localparam int UPIS_BIT_HS_CHANGE = 5;
  localparam int UPIS_BIT_DMA       = 6;
  localparam int UPIS_BIT_VBUS      = 7;
  localparam int UPIS_BIT_SETUP     = 8;
  localparam int UPIS_BIT_CTL_RX    = 10;
  localparam int UPIS_BIT_CTL_TX    = 11;
  localparam int UPIS_BIT_EP_RX_0   = 10;  // Endpoint n receive flag at 10 + 2n
  localparam int UPIS_BIT_EP_TX_0   = 11;  // Endpoint n transmit flag at 11 + 2n
  localparam int UPIS_BIT_OTG       = 0;   // In the control register
  localparam int UPIS_NUM_EP        = 7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int UPIS_CLK_HZ      = 25_000_000;
  localparam int UPIS_PSEUDO_FRAME_TICK_FLAG_FS_MS  = 1;    // Full-speed pseudo frame period
  localparam int UPIS_PSEUDO_FRAME_TICK_FLAG_HS_US  = 125;  // High-speed pseudo frame period
  localparam int UPIS_SE0_MS      = 2;    // Single-ended zero hold time
  localparam int UPIS_PSEUDO_FRAME_TICK_FLAG_FS_CYC = UPIS_CLK_HZ / 1000 * UPIS_PSEUDO_FRAME_TICK_FLAG_FS_MS;
  localparam int UPIS_PSEUDO_FRAME_TICK_FLAG_HS_CYC = UPIS_CLK_HZ / 1_000_000 * UPIS_PSEUDO_FRAME_TICK_FLAG_HS_US;
  localparam int UPIS_SE0_CYC     = UPIS_CLK_HZ / 1000 * UPIS_SE0_MS;
  localparam int UPIS_CNT_W       = 17;

endpackage : upis_pkg

/* upis_frame_timer.sv */
module upis_frame_timer
  import upis_pkg::*;
#(
  parameter int FS_CYC = UPIS_PSEUDO_FRAME_TICK_FLAG_FS_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Mode and tick
  input  wire logic hs_mode,
  output logic      tick_reg
);

  // ---------------------------------------------------------------
  // Free-running divider
  // ---------------------------------------------------------------
  logic [UPIS_CNT_W-1:0] cnt_reg;      // Cycles left in period
  logic [UPIS_CNT_W-1:0] cnt_next;
  logic                  tick_next;
  logic                  mode_reg;     // Mode seen last cycle
  logic [UPIS_CNT_W-1:0] period;       // Current period minus one

  // Period chosen by link speed; no relation to bus frames
  always_comb begin
    period    = hs_mode ? UPIS_CNT_W'(UPIS_PSEUDO_FRAME_TICK_FLAG_HS_CYC - 1) : UPIS_CNT_W'(FS_CYC - 1);
    tick_next = 1'b0;
    cnt_next  = cnt_reg - 1'b1;
    // Restart on a speed change so a stale long count is not kept
    if (mode_reg != hs_mode) begin
      cnt_next = period;
    end else if (cnt_reg == '0) begin
      cnt_next  = period;
      tick_next = 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= UPIS_CNT_W'(FS_CYC - 1);  // Same period as the running count
      tick_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
      mode_reg <= hs_mode;
    end
  end

endmodule : upis_frame_timer

/* upis_top.sv */
// Chosen here: strobed register access and the register addresses.
module upis_top
  import upis_pkg::*;
#(
  parameter int PSEUDO_FRAME_TICK_FLAG_FS_CYC = UPIS_PSEUDO_FRAME_TICK_FLAG_FS_CYC,  // Shorten in simulation
  parameter int SE0_CYC     = UPIS_SE0_CYC       // Shorten in simulation
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_reg,
  // Endpoint events, one-cycle pulses
  input  wire logic [6:0]  ep_tx_event,
  input  wire logic [6:0]  ep_rx_event,
  input  wire logic        ctl_tx_event,
  input  wire logic        ctl_rx_event,
  input  wire logic        ctl_setup_event,
  // Bus events from the link logic
  input  wire logic        dma_change_event,
  input  wire logic        sof_event,
  input  wire logic        bus_reset_event,
  input  wire logic        hs_mode,
  input  wire logic        suspend_state,
  // Pins
  input  wire logic        vbus_pin,
  input  wire logic        dp_pin,
  input  wire logic        dm_pin,
  // Interrupt
  output logic             irq_reg
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_sync_reg;  // First stage
  logic rst_n;         // Released reset for the rest

  // Async assert, two-flop release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_sync_reg <= 1'b1;
      rst_n        <= rst_sync_reg;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_s1_reg;  // First stage, read by second only
  logic [2:0] pin_s2_reg;  // Safe copy: vbus, dp, dm
  logic       vbus_d_reg;  // For edge detect

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      vbus_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {vbus_pin, dp_pin, dm_pin};
      pin_s2_reg <= pin_s1_reg;
      vbus_d_reg <= pin_s2_reg[2];
    end
  end

  // ---------------------------------------------------------------
  // Pseudo frame timer
  // ---------------------------------------------------------------
  logic pseudo_frame_tick_flag_tick;  // One pulse per pseudo frame

  upis_frame_timer #(
    .FS_CYC (PSEUDO_FRAME_TICK_FLAG_FS_CYC)
  ) u_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .hs_mode  (hs_mode),
    .tick_reg (pseudo_frame_tick_flag_tick)
  );

  // ---------------------------------------------------------------
  // Mode edge tracking and SE0 timer
  // ---------------------------------------------------------------
  logic                  hs_d_reg;       // Previous speed
  logic                  suspend_flag_d_reg;     // Previous suspend state
  logic [UPIS_CNT_W-1:0] se0_cnt_reg;    // SE0 hold counter
  logic [UPIS_CNT_W-1:0] se0_cnt_next;
  logic                  se0_hit;        // SE0 just reached 2 ms
  logic                  se0_now;        // Both data lines low

  // Counter saturates so one long SE0 gives one event
  always_comb begin
    se0_now      = ~pin_s2_reg[1] & ~pin_s2_reg[0];
    se0_hit      = 1'b0;
    se0_cnt_next = se0_cnt_reg;
    if (!se0_now) begin
      se0_cnt_next = '0;
    end else if (se0_cnt_reg < UPIS_CNT_W'(SE0_CYC)) begin
      se0_cnt_next = se0_cnt_reg + 1'b1;
      se0_hit      = (se0_cnt_reg == UPIS_CNT_W'(SE0_CYC - 1));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_d_reg    <= 1'b0;
      suspend_flag_d_reg  <= 1'b0;
      se0_cnt_reg <= '0;
    end else begin
      hs_d_reg    <= hs_mode;
      suspend_flag_d_reg  <= suspend_state;
      se0_cnt_reg <= se0_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Event vector
  // ---------------------------------------------------------------
  logic        otg_reg;      // On-the-go control bit
  logic        otg_next;
  logic        bus_rst_evt;  // Flagged bus reset
  logic [31:0] set_vec;      // Hardware sets, one per flag

  // Endpoint flags placed in pairs by index
  genvar gi;
  generate
    for (gi = 1; gi <= UPIS_NUM_EP; gi++) begin : g_ep
      assign set_vec[UPIS_BIT_EP_TX_0 + 2*gi] = ep_tx_event[gi-1];
      assign set_vec[UPIS_BIT_EP_RX_0 + 2*gi] = ep_rx_event[gi-1];
    end
  endgenerate

  // Reserved positions never set
  assign set_vec[31:26] = 6'h00;
  assign set_vec[9]     = 1'b0;
  assign set_vec[UPIS_BIT_CTL_TX] = ctl_tx_event;
  assign set_vec[UPIS_BIT_CTL_RX] = ctl_rx_event;
  assign set_vec[UPIS_BIT_SETUP]  = ctl_setup_event;
  // Low byte in documented order
  assign set_vec[UPIS_BIT_VBUS]      = pin_s2_reg[2] & ~vbus_d_reg;
  assign set_vec[UPIS_BIT_DMA]       = dma_change_event;
  // Only a rise to high speed; entering suspend never sets it
  assign set_vec[UPIS_BIT_HS_CHANGE] = hs_mode & ~hs_d_reg & ~suspend_state;
  assign set_vec[UPIS_BIT_RESUME]    = ~suspend_state & suspend_flag_d_reg;
  assign set_vec[UPIS_BIT_SUSPEND]   = suspend_state & ~suspend_flag_d_reg;
  assign set_vec[UPIS_BIT_PSEUDO_FRAME_TICK_FLAG]      = pseudo_frame_tick_flag_tick;
  assign set_vec[UPIS_BIT_SOF]       = sof_event;
  // With on-the-go set the bit reports a long SE0 instead
  assign set_vec[UPIS_BIT_BUS_RESET] = otg_reg ? se0_hit : 1'b0;
  assign bus_rst_evt = bus_reset_event & ~otg_reg;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [31:0] status_reg;   // Sticky flags
  logic [31:0] status_next;
  logic [31:0] mask_reg;     // Interrupt mask
  logic [31:0] mask_next;
  logic [31:0] clr_vec;      // Write-one-to-clear
  logic [31:0] rdata_next;
  logic        irq_next;

  // Next state of flags, mask, control and read data
  always_comb begin
    clr_vec    = 32'h0000_0000;
    mask_next  = mask_reg;
    otg_next   = otg_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr) begin
      if (reg_addr == UPIS_OFS_STATUS) begin
        clr_vec = reg_wdata;
      end else if (reg_addr == UPIS_OFS_MASK) begin
        mask_next = reg_wdata & UPIS_IMPL_MASK;
      end else if (reg_addr == UPIS_OFS_CTRL) begin
        otg_next = reg_wdata[UPIS_BIT_OTG];
      end
    end
    // Unmapped reads return zero
    if (reg_rd) begin
      if (reg_addr == UPIS_OFS_STATUS) begin
        rdata_next = status_reg;
      end else if (reg_addr == UPIS_OFS_MASK) begin
        rdata_next = mask_reg;
      end else if (reg_addr == UPIS_OFS_CTRL) begin
        rdata_next = {31'h0000_0000, otg_reg};
      end
    end
    // Set beats clear so a race with software loses nothing
    status_next = ((status_reg & ~clr_vec) | set_vec) & UPIS_IMPL_MASK;
    // Bus reset wipes the rest, leaves only its own flag
    if (bus_rst_evt) begin
      status_next = UPIS_BUSRST_VAL;
    end
    irq_next = |(status_next & mask_next);
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg    <= UPIS_STATUS_RST;
      mask_reg      <= UPIS_MASK_RST;
      otg_reg       <= 1'b0;
      reg_rdata_reg <= 32'h0000_0000;
      irq_reg       <= 1'b0;
    end else begin
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      otg_reg       <= otg_next;
      reg_rdata_reg <= rdata_next;
      irq_reg       <= irq_next;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Reserved bits never seen set
  AST_RESERVED: assert property (status_reg[31:26] == 6'h00 && !status_reg[9])
    else $error("Reserved flag bit set");

  // Endpoint 7 transmit lands on bit 25
  AST_EP7_TX: assert property (ep_tx_event[6] && !bus_rst_evt |=> status_reg[25])
    else $error("Endpoint 7 transmit flag missing");

  // Endpoint 1 receive lands on bit 12
  AST_EP1_RX: assert property (ep_rx_event[0] && !bus_rst_evt |=> status_reg[12])
    else $error("Endpoint 1 receive flag missing");

  // Control transmit lands on bit 11
  AST_CTL_TX: assert property (ctl_tx_event && !bus_rst_evt |=> status_reg[11])
    else $error("Control transmit flag missing");

  // Frame event lands on bit 1
  AST_SOF: assert property (sof_event && !bus_rst_evt |=> status_reg[1])
    else $error("Frame flag missing");

  // Flags empty right after reset release
  AST_HW_RST: assert property ($rose(rst_n) |-> status_reg == 32'h0000_0000)
    else $error("Flags not cleared by reset");

  // Bus reset leaves only bit 0
  AST_BUS_RST: assert property (bus_rst_evt |=> status_reg == UPIS_BUSRST_VAL)
    else $error("Bus reset pattern wrong");

  // Read returns flags of the request cycle
  AST_READ: assert property (reg_rd && reg_addr == UPIS_OFS_STATUS |=> reg_rdata_reg == $past(status_reg))
    else $error("Status read data wrong");

  // Setup token lands on bit 8
  AST_SETUP: assert property (ctl_setup_event && !bus_rst_evt |=> status_reg[8])
    else $error("Setup flag missing");

  // Pseudo frame tick reaches bit 2
  AST_PSEUDO_FRAME_TICK_FLAG: assert property (pseudo_frame_tick_flag_tick && !bus_rst_evt |=> status_reg[2])
    else $error("Pseudo frame flag missing");

  // Speed rise sets bit 5
  AST_HS: assert property (hs_mode && !hs_d_reg && !suspend_state && !bus_rst_evt |=> status_reg[5])
    else $error("High-speed flag missing");

  // On-the-go masks bus reset
  AST_OTG: assert property (otg_reg && bus_reset_event
                            |=> status_reg != UPIS_BUSRST_VAL || $past(status_reg[0]))
    else $error("Bus reset flagged in on-the-go mode");

  // Flag held until cleared
  AST_STICKY: assert property (status_reg[3] && !(reg_wr && reg_addr == UPIS_OFS_STATUS && reg_wdata[3])
                               && !bus_rst_evt |=> status_reg[3])
    else $error("Suspend flag lost");

  // Supply rise after sync lands on bit 7
  AST_VBUS: assert property (pin_s2_reg[2] && !vbus_d_reg && !bus_rst_evt |=> status_reg[7])
    else $error("Supply rise flag missing");

  // DMA change lands on bit 6
  AST_DMA: assert property (dma_change_event && !bus_rst_evt |=> status_reg[6])
    else $error("DMA change flag missing");

  // Entering suspend lands on bit 3
  AST_SUSPEND_FLAG: assert property (suspend_state && !suspend_flag_d_reg && !bus_rst_evt |=> status_reg[3])
    else $error("Suspend flag missing");

  // Leaving suspend lands on bit 4
  AST_RESUME: assert property (!suspend_state && suspend_flag_d_reg && !bus_rst_evt |=> status_reg[4])
    else $error("Resume flag missing");

  // No speed flag appears while suspended
  AST_HS_SUSPEND_FLAG: assert property (suspend_state && !status_reg[5] |=> !status_reg[5])
    else $error("High-speed flag set in suspend");

  // Long single-ended zero reported on bit 0
  AST_SE0: assert property (otg_reg && se0_hit |=> status_reg[0])
    else $error("Single-ended zero flag missing");

  // Interrupt follows unmasked flags
  AST_IRQ: assert property (irq_reg == |(status_reg & mask_reg))
    else $error("Interrupt output mismatch");

endmodule : upis_top

/* upis_host_model.sv */
module upis_host_model
  import upis_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Register port, host side
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata_reg
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Host bus cycles
  // ------------------------------------------------------------
  // Idle bus at time zero, before the first request
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write; flag writes are write-one-to-clear
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read; data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata_reg;
  endtask : rd
endmodule : upis_host_model

/* testbench.sv */
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  import upis_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int FS_CYC = 50;  // Short pseudo frame for simulation
  localparam int SE0_N  = 40;  // Short single-ended zero hold
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_reg, s;
  logic        reg_wr, reg_rd, irq_reg;
  logic [19:0] ev = '0;        // Packed event pulses, see instance
  logic        hs_mode = 1'b0, suspend_state = 1'b0;
  logic        vbus_pin = 1'b0, dp_pin = 1'b1, dm_pin = 1'b0;
  int          n_errors = 0, checks_done = 0, cyc = 0;

  // ------------------------------------------------------------
  // Clock, timeout and instances
  // ------------------------------------------------------------
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the few hundred cycles the tests take
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  upis_host_model host_inst (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg));

  upis_top #(.PSEUDO_FRAME_TICK_FLAG_FS_CYC(FS_CYC), .SE0_CYC(SE0_N)) upis_top_inst (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
    .ep_tx_event(ev[6:0]), .ep_rx_event(ev[13:7]), .ctl_tx_event(ev[14]),
    .ctl_rx_event(ev[15]), .ctl_setup_event(ev[16]), .dma_change_event(ev[17]),
    .sof_event(ev[18]), .bus_reset_event(ev[19]), .hs_mode(hs_mode),
    .suspend_state(suspend_state), .vbus_pin(vbus_pin), .dp_pin(dp_pin),
    .dm_pin(dm_pin), .irq_reg(irq_reg));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // One-cycle pulse on the chosen event inputs
  task automatic pulse(input logic [19:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= '0;
    #1;
  endtask : pulse

  // Status read; pseudo frame bit hidden since its timer runs free
  task automatic rds(output logic [31:0] v);
    host_inst.rd(UPIS_OFS_STATUS, v);
    v = v & ~32'h0000_0004;
  endtask : rds

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    host_inst.rd(UPIS_OFS_STATUS, s);
    `CHK("status reset", 32'h0, s)
    // Endpoint flags, sticky until cleared by the host
    for (int n = 1; n <= 7; n++) begin
      pulse(20'(1) << (n - 1));
      pulse(20'(1) << (n + 6));
      rds(s);
      `CHK("ep flags", (32'h1 << (11 + 2 * n)) | (32'h1 << (10 + 2 * n)), s)
      rds(s);
      `CHK("ep sticky", (32'h1 << (11 + 2 * n)) | (32'h1 << (10 + 2 * n)), s)
      host_inst.wr(UPIS_OFS_STATUS, 32'hFFFF_FFFF);
      rds(s);
      `CHK("ep cleared", 32'h0, s)
    end
    // Control endpoint and setup token, bit 9 stays clear
    pulse(20'h1C000);
    rds(s);
    `CHK("ctl flags", 32'h0000_0D00, s)
    host_inst.wr(UPIS_OFS_STATUS, 32'hFFFF_FFFF);
    // Low byte order: dma, sof, suspend, resume, hs, vbus
    pulse(20'h60000);
    suspend_state <= 1'b1;
    @(posedge sys_clk);
    suspend_state <= 1'b0;
    @(posedge sys_clk);
    hs_mode <= 1'b1;
    vbus_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rds(s);
    `CHK("low byte", 32'h0000_00FA, s)
    // No speed flag when the rise comes while suspended
    hs_mode <= 1'b0;
    suspend_state <= 1'b1;
    host_inst.wr(UPIS_OFS_STATUS, 32'hFFFF_FFFF);
    hs_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rds(s);
    `CHK("hs in suspend", 32'h0, s & 32'h20)
    hs_mode <= 1'b0;
    suspend_state <= 1'b0;
    // Reserved bits never stick, unmapped read gives zero
    host_inst.wr(UPIS_OFS_MASK, 32'hFFFF_FFFF);
    host_inst.rd(UPIS_OFS_MASK, s);
    `CHK("mask impl", UPIS_IMPL_MASK, s)
    host_inst.rd(8'h40, s);
    `CHK("unmapped", 32'h0, s)
    // Interrupt raised, masked and cleared
    host_inst.wr(UPIS_OFS_MASK, 32'h0000_0040);
    host_inst.wr(UPIS_OFS_STATUS, 32'hFFFF_FFFF);
    pulse(20'h00001);
    `CHK("irq masked", 1'b0, irq_reg)
    pulse(20'h20000);
    `CHK("irq set", 1'b1, irq_reg)
    host_inst.wr(UPIS_OFS_STATUS, 32'h0000_0040);
    `CHK("irq clear", 1'b0, irq_reg)
    // Bus reset leaves only its own flag
    pulse(20'h20008);
    pulse(20'h80000);
    rds(s);
    `CHK("bus reset", UPIS_BUSRST_VAL, s)
    // Pseudo frame tick at the full-speed period
    host_inst.wr(UPIS_OFS_STATUS, 32'hFFFF_FFFF);
    repeat (FS_CYC + 5) @(posedge sys_clk);
    host_inst.rd(UPIS_OFS_STATUS, s);
    `CHK("pseudo frame", 32'h4, s & 32'h4)
    // On-the-go: bus reset ignored, long SE0 reported
    host_inst.wr(UPIS_OFS_CTRL, 32'h0000_0001);
    host_inst.wr(UPIS_OFS_STATUS, 32'hFFFF_FFFF);
    pulse(20'h80000);
    rds(s);
    `CHK("otg no reset", 32'h0, s & 32'h1)
    dp_pin <= 1'b0;
    repeat (SE0_N + 10) @(posedge sys_clk);
    rds(s);
    `CHK("otg se0", 32'h1, s & 32'h1)
    dp_pin <= 1'b1;
    give_verdict();
  end
endmodule : testbench
